// [hdl/tributary_ais_pkg.sv]
package tributary_ais_pkg;

  // Port population and register geometry
  localparam int PORTS     = 28;
  localparam int LOW_BITS  = 16;
  localparam int HIGH_BITS = 12;
  localparam int REG_W     = 16;
  localparam int ADDR_W    = 8;

  // Control registers; a cleared bit forces all ones on its port
  localparam logic [ADDR_W-1:0] RX_LOW_ADDR  = 8'h40;
  localparam logic [ADDR_W-1:0] RX_HIGH_ADDR = 8'h42;
  localparam logic [ADDR_W-1:0] TX_LOW_ADDR  = 8'h44;
  localparam logic [ADDR_W-1:0] TX_HIGH_ADDR = 8'h46;

  // Read-only view of where all ones is really being inserted
  localparam logic [ADDR_W-1:0] RX_FORCE_LOW_ADDR  = 8'h48;
  localparam logic [ADDR_W-1:0] RX_FORCE_HIGH_ADDR = 8'h4a;
  localparam logic [ADDR_W-1:0] TX_FORCE_LOW_ADDR  = 8'h4c;
  localparam logic [ADDR_W-1:0] TX_FORCE_HIGH_ADDR = 8'h4e;

  localparam logic [PORTS-1:0] CTRL_RESET = 28'h0000000;
  localparam logic [REG_W-1:0] READ_IDLE  = 16'h0000;

  // Zero-based port indices of the inactive groups
  localparam int E3_FIRST_IDLE      = 16;
  localparam int G747_TX_FIRST_IDLE = 21;
  localparam int G747_IDLE_STRIDE   = 4;

  typedef struct packed {
    logic              wrEn;
    logic              rdEn;
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0]  wrData;
  } host_req_t;

  typedef logic [PORTS-1:0] trib_word_t;

endpackage

// [hdl/tributary_ais_insert.sv]
// How it works
// [RULE1] Every tributary port can be replaced by all ones on its own, separately per direction.
// [RULE2] Reset clears all control bits, so every port sends all ones both ways until changed.
// [RULE3] Software must set the control bits to one before live traffic passes the block.
// [RULE4] With the mux function disabled the control bits are ignored and data passes.
// [RULE5] A receive bit at zero drives all ones on that port's output, at one passes the data.
// [RULE6] A transmit bit at zero replaces that port's input by all ones, at one lets it through.
// [RULE7] Receive low register bits 0-15 are ports 1-16, high register bits 0-11 ports 17-28.
// [RULE8] Transmit low register bits 0-15 are ports 1-16, high register bits 0-11 ports 17-28.
// [RULE9] In G.747 mode every fourth port is idle and its bits in both directions do nothing.
// [RULE10] In E3 mode ports 17-28 are idle and both high register bits do nothing.
// [RULE11] In G.747 mode transmit bits for ports 22-28 do nothing.
// [RULE12] Bits 12-15 of both high registers read as zero and ignore writes.
`timescale 1ns/100ps

module trib_skid_buffer
#(
  parameter int WIDTH = 28
)
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);

  // Two entries: the output stage and a skid stage that catches the
  // word arriving in the cycle the receiver first stalls.
  logic [WIDTH-1:0] outData_r;
  logic [WIDTH-1:0] skidData_r;
  logic             outValid_r;
  logic             skidFree_r;

  wire outFree  = !outValid_r || outReady;
  wire takeIn   = inValid && skidFree_r;

  assign inReady  = skidFree_r;
  assign outData  = outData_r;
  assign outValid = outValid_r;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      outData_r  <= '0;
      skidData_r <= '0;
      outValid_r <= 1'b0;
      skidFree_r <= 1'b1;
    end
    else if (outFree)
    begin
      if (!skidFree_r)
      begin
        outData_r  <= skidData_r;
        outValid_r <= 1'b1;
        skidFree_r <= 1'b1;
      end
      else
      begin
        outData_r  <= inData;
        outValid_r <= inValid;
      end
    end
    else if (takeIn)
    begin
      skidData_r <= inData;
      skidFree_r <= 1'b0;
    end
  end

  // A stalled word stays put until taken
  a_buf_stall_hold: assert property (
    @(posedge clk) disable iff (reset)
    outValid_r && !outReady |=> outValid_r && $stable(outData_r)
  ) else $error("Buffered word changed while the receiver stalled");

  // A full buffer refuses input until the receiver drains it
  a_buf_full_refuse: assert property (
    @(posedge clk) disable iff (reset)
    !skidFree_r && !outReady |=> !skidFree_r
  ) else $error("Skid entry released without a drain");

endmodule

module tributary_ais_insert
  import tributary_ais_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire tributary_ais_pkg::host_req_t  hostReq,
  output logic [tributary_ais_pkg::REG_W-1:0] hostRdData,
  input  wire logic                          muxFunctionEnable,
  input  wire logic                          e3Mode,
  input  wire logic                          g747Mode,
  input  wire tributary_ais_pkg::trib_word_t demuxData,
  input  wire logic                          demuxValid,
  output logic                               demuxReady,
  output tributary_ais_pkg::trib_word_t      rxTributaryDataOut,
  output logic                               rxOutValid,
  input  wire logic                          rxOutReady,
  input  wire tributary_ais_pkg::trib_word_t txTributaryDataIn,
  input  wire logic                          txInValid,
  output logic                               txInReady,
  output tributary_ais_pkg::trib_word_t      muxData,
  output logic                               muxValid,
  input  wire logic                          muxReady
);

  import tributary_ais_pkg::*;

  // Zero in a control bit means substitute all ones
  trib_word_t       rxCtrl_r;
  trib_word_t       txCtrl_r;
  logic [REG_W-1:0] hostRdData_r;

  trib_word_t rxLive;
  trib_word_t txLive;
  trib_word_t rxForce;
  trib_word_t txForce;
  trib_word_t rxSub;
  trib_word_t txSub;

  // Host register decode
  wire wrRxLow  = hostReq.wrEn && (hostReq.addr == RX_LOW_ADDR);
  wire wrRxHigh = hostReq.wrEn && (hostReq.addr == RX_HIGH_ADDR);
  wire wrTxLow  = hostReq.wrEn && (hostReq.addr == TX_LOW_ADDR);
  wire wrTxHigh = hostReq.wrEn && (hostReq.addr == TX_HIGH_ADDR);

  trib_word_t rxCtrl_nxt;
  trib_word_t txCtrl_nxt;

  assign rxCtrl_nxt = {                                                    // [RULE7]
    wrRxHigh ? hostReq.wrData[HIGH_BITS-1:0] : rxCtrl_r[PORTS-1:LOW_BITS],  // [RULE12]
    wrRxLow  ? hostReq.wrData                : rxCtrl_r[LOW_BITS-1:0]
  };
  assign txCtrl_nxt = {                                                    // [RULE8]
    wrTxHigh ? hostReq.wrData[HIGH_BITS-1:0] : txCtrl_r[PORTS-1:LOW_BITS],  // [RULE12]
    wrTxLow  ? hostReq.wrData                : txCtrl_r[LOW_BITS-1:0]
  };

  // Upper four bits of the high registers have no storage
  logic [REG_W-1:0] rdMux;
  wire  [REG_W-HIGH_BITS-1:0] padZero = '0;

  assign rdMux =
    (hostReq.addr == RX_LOW_ADDR)        ? rxCtrl_r[LOW_BITS-1:0] :
    (hostReq.addr == RX_HIGH_ADDR)       ? {padZero, rxCtrl_r[PORTS-1:LOW_BITS]} :  // [RULE12]
    (hostReq.addr == TX_LOW_ADDR)        ? txCtrl_r[LOW_BITS-1:0] :
    (hostReq.addr == TX_HIGH_ADDR)       ? {padZero, txCtrl_r[PORTS-1:LOW_BITS]} :  // [RULE12]
    (hostReq.addr == RX_FORCE_LOW_ADDR)  ? rxForce[LOW_BITS-1:0] :
    (hostReq.addr == RX_FORCE_HIGH_ADDR) ? {padZero, rxForce[PORTS-1:LOW_BITS]} :
    (hostReq.addr == TX_FORCE_LOW_ADDR)  ? txForce[LOW_BITS-1:0] :
    (hostReq.addr == TX_FORCE_HIGH_ADDR) ? {padZero, txForce[PORTS-1:LOW_BITS]} :
                                           READ_IDLE;

  assign hostRdData = hostRdData_r;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rxCtrl_r     <= CTRL_RESET;  // [RULE2]
      txCtrl_r     <= CTRL_RESET;  // [RULE2]
      hostRdData_r <= READ_IDLE;
    end
    else
    begin
      rxCtrl_r <= rxCtrl_nxt;
      txCtrl_r <= txCtrl_nxt;
      if (hostReq.rdEn)
        hostRdData_r <= rdMux;
    end
  end

  // Which ports exist in the current multiplex mode
  for (genvar i = 0; i < PORTS; i++)
  begin : g_port
    localparam bit G747_HOLE = ((i + 1) % G747_IDLE_STRIDE) == 0;
    localparam bit E3_HOLE   = i >= E3_FIRST_IDLE;
    localparam bit G747_TOP  = i >= G747_TX_FIRST_IDLE;

    wire holeCommon = (g747Mode && G747_HOLE) || (e3Mode && E3_HOLE);  // [RULE9] [RULE10]

    assign rxLive[i] = !holeCommon;
    assign txLive[i] = !holeCommon && !(g747Mode && G747_TOP);         // [RULE11]
  end

  // Idle ports pass their data untouched; an all-ones pattern there
  // would be harmless but would hide a mode setting error on the line.
  assign rxForce = {PORTS{muxFunctionEnable}} & rxLive & ~rxCtrl_r;  // [RULE1] [RULE4]
  assign txForce = {PORTS{muxFunctionEnable}} & txLive & ~txCtrl_r;  // [RULE1] [RULE4]

  assign rxSub = demuxData | rxForce;          // [RULE5]
  assign txSub = txTributaryDataIn | txForce;  // [RULE6]

  // Substitution sits ahead of the buffers so a stalled word keeps
  // the insertion state it was taken with.
  trib_skid_buffer #(
    .WIDTH (PORTS)
  ) u_rx_buffer (
    .clk      (clk),
    .reset    (reset),
    .inData   (rxSub),
    .inValid  (demuxValid),
    .inReady  (demuxReady),
    .outData  (rxTributaryDataOut),
    .outValid (rxOutValid),
    .outReady (rxOutReady)
  );

  trib_skid_buffer #(
    .WIDTH (PORTS)
  ) u_tx_buffer (
    .clk      (clk),
    .reset    (reset),
    .inData   (txSub),
    .inValid  (txInValid),
    .inReady  (txInReady),
    .outData  (muxData),
    .outValid (muxValid),
    .outReady (muxReady)
  );

  // Checks

  localparam trib_word_t G747_HOLES = 28'h8888888;
  localparam trib_word_t HIGH_PORTS = 28'hfff0000;
  localparam trib_word_t G747_TX_TOP = 28'hfe00000;

  sequence s_rxDirectTake;
    demuxValid && demuxReady && (!rxOutValid || rxOutReady);
  endsequence

  sequence s_txDirectTake;
    txInValid && txInReady && (!muxValid || muxReady);
  endsequence

  a_reset_forces_all: assert property (  // [RULE2]
    @(posedge clk)
    $past(reset) && !reset |-> rxCtrl_r == '0 && txCtrl_r == '0
  ) else $error("Control bits not cleared by reset");

  a_rx_word_subst: assert property (  // [RULE5]
    @(posedge clk) disable iff (reset)
    s_rxDirectTake |=> rxOutValid &&
      rxTributaryDataOut == ($past(demuxData) | $past(rxForce))
  ) else $error("Receive word does not carry the expected all ones");

  a_tx_word_subst: assert property (  // [RULE6]
    @(posedge clk) disable iff (reset)
    s_txDirectTake |=> muxValid &&
      muxData == ($past(txTributaryDataIn) | $past(txForce))
  ) else $error("Transmit word does not carry the expected all ones");

  a_mux_off_pass: assert property (  // [RULE4]
    @(posedge clk) disable iff (reset)
    !muxFunctionEnable |-> rxSub == demuxData && txSub == txTributaryDataIn
  ) else $error("Insertion active with the mux function disabled");

  a_g747_hole_idle: assert property (  // [RULE9]
    @(posedge clk) disable iff (reset)
    g747Mode |-> (rxForce & G747_HOLES) == '0 && (txForce & G747_HOLES) == '0
  ) else $error("Idle G.747 port received all ones");

  a_e3_high_idle: assert property (  // [RULE10]
    @(posedge clk) disable iff (reset)
    e3Mode |-> (rxForce & HIGH_PORTS) == '0 && (txForce & HIGH_PORTS) == '0
  ) else $error("Port above 16 inserted in E3 mode");

  a_g747_tx_top: assert property (  // [RULE11]
    @(posedge clk) disable iff (reset)
    g747Mode |-> (txForce & G747_TX_TOP) == '0
  ) else $error("Transmit port above 21 inserted in G.747 mode");

  a_live_port_forced: assert property (  // [RULE1]
    @(posedge clk) disable iff (reset)
    muxFunctionEnable && !e3Mode && !g747Mode |-> rxForce == ~rxCtrl_r && txForce == ~txCtrl_r
  ) else $error("Active port insertion does not follow its bit");

  a_rx_low_map: assert property (  // [RULE7]
    @(posedge clk) disable iff (reset)
    wrRxLow |=> rxCtrl_r[LOW_BITS-1:0] == $past(hostReq.wrData)
  ) else $error("Receive low register write misplaced");

  a_rx_high_map: assert property (  // [RULE7]
    @(posedge clk) disable iff (reset)
    wrRxHigh |=> rxCtrl_r[PORTS-1:LOW_BITS] == $past(hostReq.wrData[HIGH_BITS-1:0])
  ) else $error("Receive high register write misplaced");

  a_tx_low_map: assert property (  // [RULE8]
    @(posedge clk) disable iff (reset)
    wrTxLow |=> txCtrl_r[LOW_BITS-1:0] == $past(hostReq.wrData)
  ) else $error("Transmit low register write misplaced");

  a_tx_high_map: assert property (  // [RULE8]
    @(posedge clk) disable iff (reset)
    wrTxHigh |=> txCtrl_r[PORTS-1:LOW_BITS] == $past(hostReq.wrData[HIGH_BITS-1:0])
  ) else $error("Transmit high register write misplaced");

  a_high_pad_zero: assert property (  // [RULE12]
    @(posedge clk) disable iff (reset)
    hostReq.rdEn && (hostReq.addr == RX_HIGH_ADDR || hostReq.addr == TX_HIGH_ADDR)
      |=> hostRdData[REG_W-1:HIGH_BITS] == '0
  ) else $error("Unused high register bits read nonzero");

endmodule

// [verification/trib_line_model.sv]
`timescale 1ns/100ps

module trib_line_model
  import tributary_ais_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     enable,
  input  wire logic                     txInReady,
  output tributary_ais_pkg::trib_word_t txTributaryDataIn,
  output logic                          txInValid,
  output logic                          rxOutReady
);
  import tributary_ais_pkg::*;
  logic [31:0] rnd;
  logic        taken;

  function automatic logic [31:0] step(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  initial
  begin
    rnd = 32'h00000057;
    taken = 1'b0;
    txInValid = 1'b0;
    txTributaryDataIn = 28'h0000000;
    rxOutReady = 1'b1;
  end

  // Ready seen before the edge moves, so sample late in the low phase
  always @(negedge clk)
  begin
    #3;
    taken = txInValid && txInReady;
  end

  // Word held until taken; idle lines toggle so a stale word cannot pass for new data
  always @(negedge clk)
  begin
    rnd = step(rnd);
    rxOutReady = rnd[1] | rnd[2];
    if (!txInValid || taken)
    begin
      txInValid = enable & rnd[3];
      txTributaryDataIn = txInValid ? rnd[31:4] : ~txTributaryDataIn;
    end
  end
endmodule

// [verification/test_tributary_ais_insert.sv]
`timescale 1ns/100ps

module test_tributary_ais_insert;
  import tributary_ais_pkg::*;
  logic             clk;
  logic             reset;
  host_req_t        hostReq;
  logic [REG_W-1:0] hostRdData;
  logic             muxFunctionEnable;
  logic             e3Mode;
  logic             g747Mode;
  trib_word_t       demuxData;
  logic             demuxValid;
  logic             demuxReady;
  trib_word_t       rxTributaryDataOut;
  logic             rxOutValid;
  logic             rxOutReady;
  trib_word_t       txTributaryDataIn;
  logic             txInValid;
  logic             txInReady;
  trib_word_t       muxData;
  logic             muxValid;
  logic             muxReady;
  logic             streamOn;
  logic             rxTaken;
  logic [31:0]      rnd;
  logic [31:0]      cfg;
  logic [31:0]      expWord;
  trib_word_t       rxCtrl;
  trib_word_t       txCtrl;
  trib_word_t       rxQ[$];
  trib_word_t       txQ[$];
  int               mismatches;
  int               checked;

  tributary_ais_insert i_dut (.clk(clk), .reset(reset), .hostReq(hostReq),
    .hostRdData(hostRdData), .muxFunctionEnable(muxFunctionEnable), .e3Mode(e3Mode),
    .g747Mode(g747Mode), .demuxData(demuxData), .demuxValid(demuxValid),
    .demuxReady(demuxReady), .rxTributaryDataOut(rxTributaryDataOut),
    .rxOutValid(rxOutValid), .rxOutReady(rxOutReady), .txTributaryDataIn(txTributaryDataIn),
    .txInValid(txInValid), .txInReady(txInReady), .muxData(muxData), .muxValid(muxValid),
    .muxReady(muxReady));

  trib_line_model i_line (.clk(clk), .enable(streamOn), .txInReady(txInReady),
    .txTributaryDataIn(txTributaryDataIn), .txInValid(txInValid), .rxOutReady(rxOutReady));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Idle ports and a disabled mux pass data untouched
  function automatic trib_word_t forceMask(input trib_word_t ctrl, input logic tx);
    trib_word_t m;
    for (int i = 0; i < PORTS; i++)
      m[i] = muxFunctionEnable && !ctrl[i] && !(e3Mode && i >= 16) && !(g747Mode && i % 4 == 3)
             && !(tx && g747Mode && i >= 21);
    return m;
  endfunction

  task automatic compare(input string what, input logic [31:0] expected, input logic [31:0] seen);
    checked++;
    if (seen !== expected)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, expected, seen);
    end
  endtask

  task automatic regWrite(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
    @(negedge clk);
    hostReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
    @(negedge clk);
    hostReq = '0;
  endtask

  task automatic regRead(input logic [ADDR_W-1:0] a, output logic [REG_W-1:0] d);
    @(negedge clk);
    hostReq = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 16'h0000};
    @(negedge clk);
    hostReq = '0;
    d = hostRdData;
  endtask

  task automatic setRegs(input logic allOnes);
    logic [REG_W-1:0] v [4];
    for (int k = 0; k < 4; k++)
    begin
      cfg = xorshift(cfg);
      v[k] = allOnes ? 16'hffff : cfg[15:0];
    end
    regWrite(RX_LOW_ADDR, v[0]);
    regWrite(RX_HIGH_ADDR, v[1]);
    regWrite(TX_LOW_ADDR, v[2]);
    regWrite(TX_HIGH_ADDR, v[3]);
    regWrite(RX_FORCE_LOW_ADDR, 16'h0000);
    rxCtrl = {v[1][11:0], v[0]};
    txCtrl = {v[3][11:0], v[2]};
  endtask

  task automatic checkRegs;
    logic [REG_W-1:0]  d;
    logic [ADDR_W-1:0] a [9];
    logic [REG_W-1:0]  e [9];
    trib_word_t        rm;
    trib_word_t        tm;
    rm = forceMask(rxCtrl, 1'b0);
    tm = forceMask(txCtrl, 1'b1);
    a = '{RX_LOW_ADDR, RX_HIGH_ADDR, TX_LOW_ADDR, TX_HIGH_ADDR, RX_FORCE_LOW_ADDR,
          RX_FORCE_HIGH_ADDR, TX_FORCE_LOW_ADDR, TX_FORCE_HIGH_ADDR, 8'h50};
    e = '{rxCtrl[15:0], {4'h0, rxCtrl[27:16]}, txCtrl[15:0], {4'h0, txCtrl[27:16]}, rm[15:0],
          {4'h0, rm[27:16]}, tm[15:0], {4'h0, tm[27:16]}, 16'h0000};
    for (int k = 0; k < 9; k++)
    begin
      regRead(a[k], d);
      compare("reg read", {16'h0, e[k]}, {16'h0, d});
    end
  endtask

  task automatic runTraffic;
    int w;
    streamOn <= 1'b1;
    repeat (80) @(negedge clk);
    streamOn <= 1'b0;
    w = 0;
    while ((rxQ.size() > 0 || txQ.size() > 0 || rxOutValid || muxValid) && w < 200)
    begin
      @(negedge clk);
      w++;
    end
    compare("queues drained", 32'h00000000, rxQ.size() + txQ.size());
  endtask

  // Receiver stalls at random; offered word held until taken
  always @(negedge clk)
  begin
    rnd = xorshift(rnd);
    muxReady = rnd[0] | rnd[1];
    if (!demuxValid || rxTaken)
    begin
      demuxValid = streamOn & rnd[2];
      demuxData = demuxValid ? rnd[31:4] : ~demuxData;
    end
  end

  // Late in the low phase every handshake input and flop output is settled
  always @(negedge clk)
  begin
    #3;
    rxTaken = demuxValid && demuxReady && !reset;
    if (rxTaken)
      rxQ.push_back(demuxData | forceMask(rxCtrl, 1'b0));
    if (txInValid && txInReady && !reset)
      txQ.push_back(txTributaryDataIn | forceMask(txCtrl, 1'b1));
    if (rxOutValid && rxOutReady)
    begin
      expWord = rxQ.size() > 0 ? {4'h0, rxQ.pop_front()} : 32'hffffffff;
      compare("rx word", expWord, {4'h0, rxTributaryDataOut});
    end
    if (muxValid && muxReady)
    begin
      expWord = txQ.size() > 0 ? {4'h0, txQ.pop_front()} : 32'hffffffff;
      compare("tx word", expWord, {4'h0, muxData});
    end
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #(5000 * 8);
    mismatches++;
    $display("Error watchdog expected finish seen timeout");
    finish_test();
  end

  initial
  begin
    rnd = 32'h00000063;
    cfg = 32'h00000063;
    reset = 1'b1;
    hostReq = '0;
    muxFunctionEnable = 1'b1;
    e3Mode = 1'b0;
    g747Mode = 1'b0;
    demuxData = 28'h0000000;
    demuxValid = 1'b0;
    muxReady = 1'b1;
    streamOn = 1'b0;
    rxTaken = 1'b0;
    rxCtrl = 28'h0000000;
    txCtrl = 28'h0000000;
    mismatches = 0;
    checked = 0;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    // Pass 0 keeps the reset state, pass 1 opens every port, then random setups
    for (int t = 0; t < 12; t++)
    begin
      if (t > 0)
      begin
        cfg = xorshift(cfg);
        e3Mode = (t > 1) & cfg[0];
        g747Mode = (t > 1) & cfg[1];
        muxFunctionEnable = (t != 2) & (t < 3 | cfg[2] | cfg[3]);
        setRegs(t == 1);
      end
      checkRegs();
      runTraffic();
      $display("test %0d done e3 %b g747 %b mux %b", t, e3Mode, g747Mode, muxFunctionEnable);
    end
    finish_test();
  end
endmodule
